// >>> hw/dbu_defines.svh
// Constants of the debug command and breakpoint unit.
`ifndef DBU_DEFINES_SVH
`define DBU_DEFINES_SVH

`define DBU_CMD_REV 8'h00
`define DBU_CMD_STAT 8'h02
`define DBU_CMD_CNT 8'h03
`define DBU_CMD_WCTL 8'h04
`define DBU_CMD_RCTL 8'h05
`define DBU_CMD_WPC 8'h06
`define DBU_CMD_RPC 8'h07
`define DBU_CMD_WREG 8'h08
`define DBU_CMD_RREG 8'h09
`define DBU_CMD_WPM 8'h0A
`define DBU_CMD_RPM 8'h0B
`define DBU_CMD_WDM 8'h0C
`define DBU_CMD_RDM 8'h0D
`define DBU_CMD_CRC 8'h0E
`define DBU_CMD_STEP 8'h10
`define DBU_CMD_STUFF 8'h11
`define DBU_CMD_EXEC 8'h12

`define DBU_CTL_HALT 7
`define DBU_CTL_BKEN 6
`define DBU_CTL_RST 0
`define DBU_CTL_RESET 8'h00
`define DBU_STAT_HALT 7
`define DBU_STAT_PROT 6

`define DBU_REG_CTL 2'h0
`define DBU_REG_STAT 2'h1
`define DBU_REG_CNTL 2'h2
`define DBU_REG_CNTH 2'h3

`define DBU_CNT_MAX 16'hFFFF
`define DBU_FILL 16'hFFFF
`define DBU_BREAK_BITS 6'd40
`define DBU_MIN_BIT 10'h002
`define DBU_STOP_IDX 6'd9

`endif

// >>> hw/dbu_pkg.sv
// Types of the debug command and breakpoint unit.
`default_nettype none
package dbu_pkg;
	typedef enum logic [2:0] {
		DBU_L_UNLK = 3'h0,
		DBU_L_MEAS = 3'h1,
		DBU_L_IDLE = 3'h2,
		DBU_L_RX = 3'h3,
		DBU_L_TX = 3'h4,
		DBU_L_BREAK = 3'h5,
		DBU_L_WHI = 3'h6
	} dbu_link_type;

	typedef enum logic [1:0] {
		DBU_P_CMD = 2'h0,
		DBU_P_HDR = 2'h1,
		DBU_P_WDAT = 2'h2,
		DBU_P_REPLY = 2'h3
	} dbu_phase_type;

	typedef enum logic [2:0] {
		DBU_K_NONE = 3'h0,
		DBU_K_REP1 = 3'h1,
		DBU_K_REP2 = 3'h2,
		DBU_K_WR8 = 3'h3,
		DBU_K_RD8 = 3'h4,
		DBU_K_WR16 = 3'h5,
		DBU_K_RD16 = 3'h6
	} dbu_kind_type;

	typedef struct packed {
		logic rsv;
		logic [2:0] hdr;
		dbu_kind_type kind;
		logic norm;
		logic blk;
	} dbu_info_type;
endpackage : dbu_pkg
`default_nettype wire

// >>> hw/dbu_debug_unit.sv
// Debug unit: breakpoints, cycle counter and one-wire command decoder.
`include "dbu_defines.svh"
`default_nettype none
module dbu_debug_unit #(
	parameter logic [15:0] REVISION = 16'h0100 // Arbitrary value.
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic debug_pin_i,
	output logic debug_pin_o,
	output logic debug_pin_oe_o,
	input wire logic bkpt_decode_i,
	input wire logic read_protect_option_i,
	input wire logic [15:0] pc_i,
	output logic cpu_halt_o,
	output logic sys_reset_o,
	output logic pc_load_o,
	output logic [15:0] pc_value_o,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o
);
	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic dbu_pkg::dbu_info_type cmd_info(input logic [7:0] c);
		dbu_pkg::dbu_info_type i;
		i = '{rsv: 1'b0, hdr: 3'h0, kind: dbu_pkg::DBU_K_NONE, norm: 1'b0, blk: 1'b0};
		case (c)
			`DBU_CMD_REV: begin
				i.kind = dbu_pkg::DBU_K_REP2;
				i.norm = 1'b1;
			end
			`DBU_CMD_STAT: begin
				i.kind = dbu_pkg::DBU_K_REP1;
				i.norm = 1'b1;
			end
			`DBU_CMD_CNT: i.kind = dbu_pkg::DBU_K_REP2;
			`DBU_CMD_WCTL: begin
				i.hdr = 3'h1;
				i.norm = 1'b1;
			end
			`DBU_CMD_RCTL: begin
				i.kind = dbu_pkg::DBU_K_REP1;
				i.norm = 1'b1;
			end
			`DBU_CMD_WPC: begin
				i.hdr = 3'h2;
				i.blk = 1'b1;
			end
			`DBU_CMD_RPC: begin
				i.kind = dbu_pkg::DBU_K_REP2;
				i.blk = 1'b1;
			end
			`DBU_CMD_WREG: begin
				i.hdr = 3'h3;
				// No register file sits behind the unit, so the data is only consumed.
				i.kind = dbu_pkg::DBU_K_WR8;
			end
			`DBU_CMD_RREG: begin
				i.hdr = 3'h3;
				i.kind = dbu_pkg::DBU_K_RD8;
				i.blk = 1'b1;
			end
			`DBU_CMD_WPM, `DBU_CMD_WDM: begin
				i.hdr = 3'h4;
				i.kind = dbu_pkg::DBU_K_WR16;
				i.blk = 1'b1;
			end
			`DBU_CMD_RPM: begin
				i.hdr = 3'h4;
				i.kind = dbu_pkg::DBU_K_RD16;
				i.blk = 1'b1;
			end
			`DBU_CMD_RDM: begin
				i.hdr = 3'h4;
				i.kind = dbu_pkg::DBU_K_RD16;
			end
			`DBU_CMD_CRC: i.kind = dbu_pkg::DBU_K_REP2;
			`DBU_CMD_STEP: i.blk = 1'b1;
			`DBU_CMD_STUFF, `DBU_CMD_EXEC: begin
				i.hdr = 3'h1;
				i.blk = 1'b1;
			end
			default: i.rsv = 1'b1;
		endcase
		cmd_info = i;
	endfunction : cmd_info

	// Under protection the halt bit can only be set, never cleared.
	function automatic logic [7:0] ctl_wr(input logic [7:0] o, input logic [7:0] d,
		input logic p);
		ctl_wr = {d[7] | (p & o[7]), d[6:5], 4'h0, d[0]};
	endfunction : ctl_wr

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dbu_pkg::dbu_link_type lst_r, lst_nxt;
	dbu_pkg::dbu_phase_type ph_r, ph_nxt;
	dbu_pkg::dbu_info_type inf;
	logic [12:0] tmr_r, tmr_nxt;
	logic [9:0] bit_r, bit_nxt;
	logic [5:0] bc_r, bc_nxt;
	logic [9:0] sh_r, sh_nxt;
	logic [13:0] low_r, low_nxt;
	logic oe_r, oe_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [31:0] hb_r, hb_nxt;
	logic [16:0] cnt_r, cnt_nxt;
	logic [15:0] rep_r, rep_nxt;
	logic [7:0] ctl_r, ctl_nxt;
	logic [15:0] run_r, run_nxt;
	logic halt_q_r, halt_q_nxt;
	logic pcl_r, pcl_nxt;
	logic [15:0] pcv_r, pcv_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic rx_done;
	logic hdr_end;
	logic ok;
	logic [7:0] rxb;
	logic [7:0] cur;
	logic [31:0] hx;
	logic [15:0] val;
	logic [13:0] break_len;
	logic [7:0] stat;

	assign stat = {ctl_r[7], read_protect_option_i, 6'h00};
	assign rxb = sh_r[9:2];
	// A 00H byte is itself nine bit times low, so only ten bit times mark a break here.
	// Shorter breaks still end in a low stop sample and are caught as framing errors.
	assign break_len = {1'b0, bit_r, 3'h0} + {3'h0, bit_r, 1'b0} + 14'h000A;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		lst_nxt = lst_r;
		ph_nxt = ph_r;
		tmr_nxt = tmr_r;
		bit_nxt = bit_r;
		bc_nxt = bc_r;
		sh_nxt = sh_r;
		oe_nxt = oe_r;
		cmd_nxt = cmd_r;
		hb_nxt = hb_r;
		cnt_nxt = cnt_r;
		rep_nxt = rep_r;
		ctl_nxt = ctl_r;
		run_nxt = run_r;
		pcl_nxt = 1'b0;
		pcv_nxt = pcv_r;
		rd_nxt = 8'h00;
		rx_done = 1'b0;
		hdr_end = 1'b0;
		halt_q_nxt = ctl_r[7];
		low_nxt = (debug_pin_i || oe_r) ? 14'h0000 : low_r + {13'h0000, ~&low_r};
		if (ctl_r[`DBU_CTL_RST]) begin
			ctl_nxt[`DBU_CTL_RST] = 1'b0;
		end
		// Serial link, frames of start, eight data bits LSB first, stop.
		unique case (lst_r)
			dbu_pkg::DBU_L_UNLK: begin
				if (!debug_pin_i) begin
					lst_nxt = dbu_pkg::DBU_L_MEAS;
					tmr_nxt = 13'h0000;
				end
			end
			dbu_pkg::DBU_L_MEAS: begin
				if (debug_pin_i) begin
					bit_nxt = tmr_r[12:3];
					lst_nxt = (tmr_r[12:3] >= `DBU_MIN_BIT) ? dbu_pkg::DBU_L_IDLE :
						dbu_pkg::DBU_L_UNLK;
				end else begin
					tmr_nxt = tmr_r + {12'h000, ~&tmr_r};
				end
			end
			dbu_pkg::DBU_L_IDLE: begin
				if (!debug_pin_i) begin
					lst_nxt = dbu_pkg::DBU_L_RX;
					tmr_nxt = {4'h0, bit_r[9:1]};
					bc_nxt = 6'h00;
				end else if (ph_r == dbu_pkg::DBU_P_REPLY && cnt_r != 17'h00000) begin
					lst_nxt = dbu_pkg::DBU_L_TX;
					sh_nxt = {1'b1, rep_r[15:8], 1'b0};
					rep_nxt = {rep_r[7:0], 8'hFF};
					cnt_nxt = cnt_r - 17'h00001;
					tmr_nxt = {3'h0, bit_r};
					bc_nxt = 6'h00;
					oe_nxt = 1'b1;
				end
			end
			dbu_pkg::DBU_L_RX: begin
				if (tmr_r == 13'h0000) begin
					tmr_nxt = {3'h0, bit_r};
					bc_nxt = bc_r + 6'h01;
					sh_nxt = {debug_pin_i, sh_r[9:1]};
					if (bc_r == 6'h00 && debug_pin_i) begin
						lst_nxt = dbu_pkg::DBU_L_IDLE;
					end else if (bc_r == `DBU_STOP_IDX) begin
						lst_nxt = dbu_pkg::DBU_L_IDLE;
						rx_done = debug_pin_i;
					end
				end else begin
					tmr_nxt = tmr_r - 13'h0001;
				end
			end
			dbu_pkg::DBU_L_TX: begin
				if (tmr_r == 13'h0000) begin
					tmr_nxt = {3'h0, bit_r};
					bc_nxt = bc_r + 6'h01;
					sh_nxt = {1'b1, sh_r[9:1]};
					oe_nxt = ~sh_r[1];
					if (bc_r == `DBU_STOP_IDX) begin
						lst_nxt = dbu_pkg::DBU_L_IDLE;
						oe_nxt = 1'b0;
						if (cnt_r == 17'h00000) begin
							ph_nxt = dbu_pkg::DBU_P_CMD;
						end
					end
				end else begin
					tmr_nxt = tmr_r - 13'h0001;
				end
			end
			dbu_pkg::DBU_L_BREAK: begin
				if (tmr_r == 13'h0000) begin
					tmr_nxt = {3'h0, bit_r};
					bc_nxt = bc_r + 6'h01;
					if (bc_r == `DBU_BREAK_BITS - 6'h01) begin
						lst_nxt = dbu_pkg::DBU_L_WHI;
						oe_nxt = 1'b0;
					end
				end else begin
					tmr_nxt = tmr_r - 13'h0001;
				end
			end
			dbu_pkg::DBU_L_WHI: begin
				// The baud detector restarts only once the host lets the line go.
				if (debug_pin_i) begin
					lst_nxt = dbu_pkg::DBU_L_UNLK;
				end
			end
			default: lst_nxt = dbu_pkg::DBU_L_UNLK;
		endcase
		// Command decoder.
		cur = (ph_r == dbu_pkg::DBU_P_CMD) ? rxb : cmd_r;
		inf = cmd_info(cur);
		hx = {hb_r[23:0], rxb};
		if (rx_done) begin
			unique case (ph_r)
				dbu_pkg::DBU_P_CMD: begin
					cmd_nxt = rxb;
					if (!inf.rsv) begin
						if (inf.hdr == 3'h0) begin
							hdr_end = 1'b1;
						end else begin
							ph_nxt = dbu_pkg::DBU_P_HDR;
							cnt_nxt = {14'h0000, inf.hdr};
						end
					end
				end
				dbu_pkg::DBU_P_HDR: begin
					hb_nxt = hx;
					cnt_nxt = cnt_r - 17'h00001;
					hdr_end = (cnt_r == 17'h00001);
				end
				dbu_pkg::DBU_P_WDAT: begin
					cnt_nxt = cnt_r - 17'h00001;
					if (cnt_r == 17'h00001) begin
						ph_nxt = dbu_pkg::DBU_P_CMD;
					end
				end
				dbu_pkg::DBU_P_REPLY: begin
				end
			endcase
		end
		ok = ctl_r[7] ? !(read_protect_option_i && inf.blk) : inf.norm;
		case (cur)
			`DBU_CMD_REV: val = REVISION;
			`DBU_CMD_STAT: val = {stat, 8'hFF};
			`DBU_CMD_CNT: val = run_r;
			`DBU_CMD_RCTL: val = {ctl_r, 8'hFF};
			`DBU_CMD_RPC: val = pc_i;
			default: val = `DBU_FILL;
		endcase
		if (hdr_end) begin
			ph_nxt = dbu_pkg::DBU_P_CMD;
			rep_nxt = ok ? val : `DBU_FILL;
			if (ok && cur == `DBU_CMD_WCTL) begin
				ctl_nxt = ctl_wr(ctl_r, hx[7:0], read_protect_option_i);
			end
			if (ok && cur == `DBU_CMD_WPC) begin
				pcl_nxt = 1'b1;
				pcv_nxt = hx[15:0];
			end
			if (ok && cur >= `DBU_CMD_WREG) begin
				run_nxt = 16'h0000;
			end
			unique case (inf.kind)
				dbu_pkg::DBU_K_REP1, dbu_pkg::DBU_K_REP2: begin
					ph_nxt = dbu_pkg::DBU_P_REPLY;
					cnt_nxt = (inf.kind == dbu_pkg::DBU_K_REP2) ? 17'h00002 : 17'h00001;
				end
				dbu_pkg::DBU_K_WR8, dbu_pkg::DBU_K_RD8: begin
					ph_nxt = (inf.kind == dbu_pkg::DBU_K_WR8) ? dbu_pkg::DBU_P_WDAT :
						dbu_pkg::DBU_P_REPLY;
					cnt_nxt = (hx[7:0] == 8'h00) ? 17'h00100 : {9'h000, hx[7:0]};
				end
				dbu_pkg::DBU_K_WR16, dbu_pkg::DBU_K_RD16: begin
					ph_nxt = (inf.kind == dbu_pkg::DBU_K_WR16) ? dbu_pkg::DBU_P_WDAT :
						dbu_pkg::DBU_P_REPLY;
					cnt_nxt = (hx[15:0] == 16'h0000) ? 17'h10000 : {1'b0, hx[15:0]};
				end
				dbu_pkg::DBU_K_NONE: begin
				end
			endcase
		end
		// Break from host, framing error or collision abandons the command.
		if (((lst_r == dbu_pkg::DBU_L_IDLE || lst_r == dbu_pkg::DBU_L_RX ||
			lst_r == dbu_pkg::DBU_L_TX) && low_r >= break_len) ||
			(lst_r == dbu_pkg::DBU_L_RX && tmr_r == 13'h0000 && bc_r == `DBU_STOP_IDX &&
			!debug_pin_i) ||
			(lst_r == dbu_pkg::DBU_L_TX && !oe_r && !debug_pin_i &&
			tmr_r == {4'h0, bit_r[9:1]})) begin
			lst_nxt = dbu_pkg::DBU_L_BREAK;
			ph_nxt = dbu_pkg::DBU_P_CMD;
			oe_nxt = 1'b1;
			bc_nxt = 6'h00;
			tmr_nxt = {3'h0, bit_r};
		end
		// Software register port.
		if (reg_wr_i && reg_addr_i == `DBU_REG_CTL) begin
			ctl_nxt = ctl_wr(ctl_r, reg_wdata_i, read_protect_option_i);
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`DBU_REG_CTL: rd_nxt = ctl_r;
				`DBU_REG_STAT: rd_nxt = stat;
				`DBU_REG_CNTL: rd_nxt = run_r[7:0];
				`DBU_REG_CNTH: rd_nxt = run_r[15:8];
				default: rd_nxt = 8'h00;
			endcase
		end
		// A breakpoint beats a simultaneous write clearing the halt bit.
		if (bkpt_decode_i && ctl_r[`DBU_CTL_BKEN]) begin
			ctl_nxt[`DBU_CTL_HALT] = 1'b1;
		end
		// Cycle counter restarts from zero on leaving debug mode.
		if (!ctl_r[7]) begin
			if (halt_q_r) begin
				run_nxt = 16'h0000;
			end else if (run_r != `DBU_CNT_MAX) begin
				run_nxt = run_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			lst_r <= dbu_pkg::DBU_L_UNLK;
			ph_r <= dbu_pkg::DBU_P_CMD;
			tmr_r <= 13'h0000;
			bit_r <= 10'h000;
			bc_r <= 6'h00;
			sh_r <= 10'h3FF;
			low_r <= 14'h0000;
			oe_r <= 1'b0;
			cmd_r <= 8'h00;
			hb_r <= 32'h00000000;
			cnt_r <= 17'h00000;
			rep_r <= 16'h0000;
			ctl_r <= `DBU_CTL_RESET;
			run_r <= 16'h0000;
			halt_q_r <= 1'b0;
			pcl_r <= 1'b0;
			pcv_r <= 16'h0000;
			rd_r <= 8'h00;
		end else begin
			lst_r <= lst_nxt;
			ph_r <= ph_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			bc_r <= bc_nxt;
			sh_r <= sh_nxt;
			low_r <= low_nxt;
			oe_r <= oe_nxt;
			cmd_r <= cmd_nxt;
			hb_r <= hb_nxt;
			cnt_r <= cnt_nxt;
			rep_r <= rep_nxt;
			ctl_r <= ctl_nxt;
			run_r <= run_nxt;
			halt_q_r <= halt_q_nxt;
			pcl_r <= pcl_nxt;
			pcv_r <= pcv_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Open-drain pin: only ever pulled low.
	assign debug_pin_o = 1'b0;
	assign debug_pin_oe_o = oe_r;
	assign cpu_halt_o = ctl_r[`DBU_CTL_HALT];
	assign sys_reset_o = ctl_r[`DBU_CTL_RST];
	assign pc_load_o = pcl_r;
	assign pc_value_o = pcv_r;
	assign reg_rdata_o = rd_r;
endmodule : dbu_debug_unit
`default_nettype wire

// >>> verif/dbu_debug_unit_assertions.sv
// Port assertions of the debug unit, bound to its top module.
`default_nettype none
module dbu_debug_unit_sva (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic debug_pin_oe_o,
	input wire logic read_protect_option_i,
	input wire logic bkpt_decode_i,
	input wire logic cpu_halt_o,
	input wire logic pc_load_o,
	input wire logic [15:0] pc_value_o,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	// ----
	// Properties
	// ----
	// The shortest bit is three cycles, so a shorter low pulse is a broken generator.
	sequence s_low_rise;
		$rose(debug_pin_oe_o);
	endsequence
	sequence s_low_hold;
		debug_pin_oe_o [*2];
	endsequence
	property p_tx_bit;
		s_low_rise |=> s_low_hold;
	endproperty
	a_tx_bit: assert property (p_tx_bit)
		else $error("pin pulled low too briefly");
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without strobe");
	property p_ctl_rd;
		reg_rd_i && reg_addr_i == 2'h0 |=> reg_rdata_o[7] == $past(cpu_halt_o)
			&& reg_rdata_o[4:1] == 4'h0;
	endproperty
	a_ctl_rd: assert property (p_ctl_rd)
		else $error("control read wrong");
	property p_stat_rd;
		reg_rd_i && reg_addr_i == 2'h1 |=> reg_rdata_o ==
			{$past(cpu_halt_o), $past(read_protect_option_i), 6'h00};
	endproperty
	a_stat_rd: assert property (p_stat_rd)
		else $error("status read wrong");
	property p_prot_keep;
		read_protect_option_i && cpu_halt_o |=> cpu_halt_o;
	endproperty
	a_prot_keep: assert property (p_prot_keep)
		else $error("halt cleared under protection");
	property p_ctl_wr;
		logic w;
		(reg_wr_i && reg_addr_i == 2'h0 && !bkpt_decode_i && !read_protect_option_i,
			w = reg_wdata_i[7]) |=> cpu_halt_o == w;
	endproperty
	a_ctl_wr: assert property (p_ctl_wr)
		else $error("control write lost");
	property p_pc_pulse;
		pc_load_o |=> !pc_load_o;
	endproperty
	a_pc_pulse: assert property (p_pc_pulse)
		else $error("pc load longer than one cycle");
	property p_pc_gate;
		pc_load_o |-> cpu_halt_o && !read_protect_option_i;
	endproperty
	a_pc_gate: assert property (p_pc_gate)
		else $error("pc loaded while not allowed");
	property p_pcv_hold;
		$changed(pc_value_o) |-> pc_load_o;
	endproperty
	a_pcv_hold: assert property (p_pcv_hold)
		else $error("pc value moved without load");
	property p_reset_state;
		$rose(reset_n_i) |-> !cpu_halt_o && !debug_pin_oe_o && pc_value_o == 16'h0000;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("state not cleared by reset");
endmodule : dbu_debug_unit_sva
bind dbu_debug_unit dbu_debug_unit_sva u_sva (
	.clk_sys_i,
	.reset_n_i,
	.debug_pin_oe_o,
	.read_protect_option_i,
	.bkpt_decode_i,
	.cpu_halt_o,
	.pc_load_o,
	.pc_value_o,
	.reg_addr_i,
	.reg_wdata_i,
	.reg_wr_i,
	.reg_rd_i,
	.reg_rdata_o
);
`default_nettype wire

// >>> verif/dbu_host_model.sv
// Model of the external debug host on the open-drain debug pin.
`default_nettype none
module dbu_host_model #(
	parameter int BIT = 32
) (
	input wire logic clk_i,
	input wire logic pin_i,
	output logic low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Byte transfer
	// ----
	// The host only pulls low, so a reply that starts at once never fights a driven stop.
	initial low_o = 1'b0;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			low_o <= !f[i];
			// The stop bit is cut short: the unit may answer right after its stop sample.
			repeat ((i == 9) ? BIT / 2 + 2 : BIT - 1) @(posedge clk_i);
		end
	endtask : send
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (pin_i && n < 5000) begin
			@(posedge clk_i);
			n++;
		end
		ok = !pin_i;
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			b[i] = pin_i;
		end
		// Return at mid stop bit, so that the next call still sees the next start edge.
		repeat (BIT) @(posedge clk_i);
		ok = ok && pin_i;
	endtask : recv
	task automatic hold_low(input int n);
		@(posedge clk_i);
		low_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		low_o <= 1'b0;
	endtask : hold_low
endmodule : dbu_host_model
`default_nettype wire

// >>> verif/tb_dbu_debug_unit.sv
// Self-checking testbench of the debug unit.
`default_nettype none
module tb_dbu_debug_unit;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 32;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic bkpt_decode_i = 1'b0;
	logic prot = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic pin;
	logic pin_o;
	logic pin_oe;
	logic host_low;
	logic cpu_halt_o;
	logic pc_load_o;
	logic [15:0] pc_value_o;
	logic [15:0] pc_seen = 16'h0000;
	int pc_loads = 0;
	int bad_count = 0;
	int num_checks = 0;
	// ----
	// Harness
	// ----
	assign pin = !(host_low || (pin_oe && !pin_o));
	always #20 clk_sys_i = !clk_sys_i;
	dbu_debug_unit uut (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.debug_pin_i(pin),
		.debug_pin_o(pin_o),
		.debug_pin_oe_o(pin_oe),
		.bkpt_decode_i(bkpt_decode_i),
		.read_protect_option_i(prot),
		.pc_i(16'hBEEF),
		.cpu_halt_o(cpu_halt_o),
		.sys_reset_o(),
		.pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o)
	);
	dbu_host_model #(.BIT(BIT)) u_host (
		.clk_i(clk_sys_i),
		.pin_i(pin),
		.low_o(host_low)
	);
	always @(posedge clk_sys_i) begin
		if (pc_load_o === 1'b1) begin
			pc_loads <= pc_loads + 1;
			pc_seen <= pc_value_o;
		end
	end
	task automatic conclude();
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rx(input int n, output logic [15:0] r);
		logic [7:0] b;
		logic ok;
		r = 16'h0000;
		for (int i = 0; i < n; i++) begin
			u_host.recv(b, ok);
			if (!ok) begin
				bad_count++;
				conclude();
			end
			r = {r[7:0], b};
		end
		repeat (BIT / 2 + 2) @(posedge clk_sys_i);
	endtask : rx
	task automatic sendw(input logic [31:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			u_host.send(w[8 * i +: 8]);
		end
	endtask : sendw
	task automatic ask(input logic [7:0] c, input int n, input logic [15:0] e, input string nm);
		logic [15:0] r;
		u_host.send(c);
		rx(n, r);
		check(nm, r, e);
	endtask : ask
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		d = reg_rdata_o;
	endtask : reg_rd
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr
	task automatic cnt(output logic [15:0] v);
		reg_rd(2'h3, v[15:8]);
		reg_rd(2'h2, v[7:0]);
	endtask : cnt
	// The CPU meets the 00H that the host planted: bkpt_decode_i is high for one cycle.
	task automatic pulse_bkpt();
		@(posedge clk_sys_i);
		bkpt_decode_i <= 1'b1;
		@(posedge clk_sys_i);
		bkpt_decode_i <= 1'b0;
		@(negedge clk_sys_i);
	endtask : pulse_bkpt
	task automatic do_reset();
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		u_host.send(8'h80);
	endtask : do_reset
	// ----
	// Scenarios
	// ----
	initial begin
		logic [7:0] d;
		logic [15:0] c1;
		logic [15:0] c2;
		int n;
		do_reset();
		reg_rd(2'h0, d);
		check("ctl reset", d, 8'h00);
		ask(8'h00, 2, 16'h0100, "revision");
		ask(8'h02, 1, 16'h0000, "status");
		ask(8'h03, 2, 16'hFFFF, "count idle");
		sendw(32'h06123401, 4);
		ask(8'h05, 1, 16'h0000, "ctl aligned");
		check("pc loads", 16'(pc_loads), 16'h0000);
		pulse_bkpt();
		check("halt off", cpu_halt_o, 1'b0);
		sendw(32'h0440, 2);
		ask(8'h05, 1, 16'h0040, "ctl");
		pulse_bkpt();
		check("halt on", cpu_halt_o, 1'b1);
		reg_rd(2'h0, d);
		check("ctl bkpt", d, 8'hC0);
		cnt(c1);
		repeat (20) @(posedge clk_sys_i);
		cnt(c2);
		check("count frozen", c2, c1);
		ask(8'h03, 2, c1, "count");
		ask(8'h02, 1, 16'h0080, "status halt");
		sendw(32'h061234, 3);
		repeat (2) @(posedge clk_sys_i);
		check("pc value", pc_seen, 16'h1234);
		ask(8'h07, 2, 16'hBEEF, "pc read");
		sendw(32'h10, 1);
		cnt(c1);
		check("count step", c1, 16'h0000);
		reg_wr(2'h0, 8'h40);
		reg_rd(2'h2, d);
		check("count restart", 16'(d < 8'h20), 16'h0001);
		u_host.hold_low(10 * BIT);
		repeat (4) @(posedge clk_sys_i);
		check("break echo", pin_oe, 1'b1);
		for (n = 0; pin_oe !== 1'b0; n++) begin
			if (n > 3000) begin
				bad_count++;
				conclude();
			end
			@(posedge clk_sys_i);
		end
		repeat (BIT) @(posedge clk_sys_i);
		u_host.send(8'h80);
		ask(8'h05, 1, 16'h0040, "ctl break");
		repeat (65536) @(posedge clk_sys_i);
		cnt(c1);
		check("count sat", c1, 16'hFFFF);
		@(posedge clk_sys_i);
		prot <= 1'b1;
		do_reset();
		sendw(32'h04800400, 4);
		ask(8'h05, 1, 16'h0080, "ctl prot");
		reg_wr(2'h0, 8'h00);
		reg_rd(2'h1, d);
		check("status prot", d, 8'hC0);
		sendw(32'h065566, 3);
		ask(8'h07, 2, 16'hFFFF, "pc prot");
		check("pc loads prot", 16'(pc_loads), 16'h0001);
		sendw(32'h09001001, 4);
		rx(1, c1);
		check("reg prot", c1, 16'h00FF);
		ask(8'h05, 1, 16'h0080, "ctl aligned");
		conclude();
	end
endmodule : tb_dbu_debug_unit
`default_nettype wire
